/* hw/sdpci_device.sv */
// sdpci_device: memory device end, four banks, sixteen-bit data, byte masks
// assumes: pins sampled on ref_clk; small array stands in for the full memory
// Functional notes
// - activate captures thirteen-bit row address
// - column from low nine or ten lines; the stand-in array uses only the low four
// - scope bit means auto-precharge on access
// - precharge scope high closes all banks
// - mode load takes op-code from address
// - bank lines pick the addressed bank
// - command decoded from three strobes, select
// - edge ignored while clock gate low
// - gate low means suspend or power-down
// - clock gate needs no edge sampling
// - other inputs captured on rising edge
// - select high ignores commands, keeps state
// - low mask lower byte, high upper
// - read lane tristated while its mask high
// - write stores only unmasked lanes
// - latch write data, drive read data
// - read mask applies two cycles later
// - precharge-all ignores the bank lines
// - row stays open until precharged
`timescale 1ns/10ps
`default_nettype none
module sdpci_device #(
  parameter int COL_W   = sdpci_pkg::COL_W_X16,
  parameter int ARR_COL = 16
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  sdpci_if.device   pins,
  output logic [sdpci_pkg::ADDR_W-1:0] mode_word,
  output logic [sdpci_pkg::BANKS-1:0]  bank_open,
  output logic                         gated
);
  // ==========================================================
  // sizes of the small stand-in array
  localparam int CW      = $clog2(ARR_COL);
  // one row bit kept per bank, so an activate really picks storage
  localparam int ARR_ROW = 2;
  localparam int RW      = $clog2(ARR_ROW);
  localparam int DEPTH   = sdpci_pkg::BANKS * ARR_ROW * ARR_COL;
  localparam int IW      = $clog2(DEPTH);
  localparam int LANE_W  = sdpci_pkg::DATA_W / sdpci_pkg::LANES;

  // ==========================================================
  // state
  typedef struct packed {
    logic [sdpci_pkg::ADDR_W-1:0]                        mode_q;
    logic [sdpci_pkg::BANKS-1:0]                         open_q;
    logic [sdpci_pkg::BANKS-1:0][sdpci_pkg::ADDR_W-1:0]  row_q;
    logic [sdpci_pkg::BANKS-1:0]                         ap_q;
    logic [sdpci_pkg::READ_LAT-1:0]                      rd_pipe_q;
    logic [sdpci_pkg::READ_LAT-1:0][sdpci_pkg::DATA_W-1:0] rd_data_q;
    logic [sdpci_pkg::MASK_DELAY-1:0][sdpci_pkg::LANES-1:0] mask_pipe_q;
    logic [sdpci_pkg::DATA_W-1:0]                        dout_q;
    logic [sdpci_pkg::LANES-1:0]                         oe_q;
    logic                                                gated_q;
  } sdpci_dev_s;

  sdpci_dev_s st_q;
  sdpci_dev_s st_d;

  // ==========================================================
  // decode
  function automatic sdpci_pkg::sdpci_op_e decode_cmd(input logic sel_n,
                                                      input logic [2:0] str);
    sdpci_pkg::sdpci_op_e op;
    op = sdpci_pkg::SDPCI_OP_NOP;
    if (!sel_n)
    begin
      case (str)
        sdpci_pkg::CMD_ACT:   op = sdpci_pkg::SDPCI_OP_ACT;
        sdpci_pkg::CMD_READ:  op = sdpci_pkg::SDPCI_OP_READ;
        sdpci_pkg::CMD_WRITE: op = sdpci_pkg::SDPCI_OP_WRITE;
        sdpci_pkg::CMD_PRE:   op = sdpci_pkg::SDPCI_OP_PRE;
        sdpci_pkg::CMD_MODE:  op = sdpci_pkg::SDPCI_OP_MODE;
        sdpci_pkg::CMD_REF:   op = sdpci_pkg::SDPCI_OP_REF;
        default:              op = sdpci_pkg::SDPCI_OP_NOP;
      endcase
    end
    return op;
  endfunction : decode_cmd

  sdpci_pkg::sdpci_op_e         op;
  logic [sdpci_pkg::BANK_W-1:0] bank;
  logic [CW-1:0]                col;
  logic [RW-1:0]                row_sel;
  logic [sdpci_pkg::LANES-1:0]  mask_now;
  logic                         scope;
  logic                         wr_hit;
  logic [IW-1:0]                mem_idx;
  wire  [sdpci_pkg::DATA_W-1:0] rd_word;

  assign op       = decode_cmd(pins.cmd_sel_n,
                    {pins.row_strobe_n, pins.col_strobe_n, pins.wr_strobe_n});
  assign bank     = {pins.bank_select_msb, pins.bank_select_lsb};
  // column lines only, scope bit excluded
  assign col      = pins.addr[CW-1:0];
  assign scope    = pins.addr[sdpci_pkg::SCOPE_BIT];
  assign mask_now = {pins.high_byte_mask, pins.low_byte_mask};
  // open row of the addressed bank picks storage
  assign row_sel  = st_q.row_q[bank][RW-1:0];
  assign mem_idx  = {bank, row_sel, col};
  assign wr_hit   = pins.clk_gate && op == sdpci_pkg::SDPCI_OP_WRITE && st_q.open_q[bank];

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // gate level used as-is, not edge sampled; held state while low
    st_d.gated_q = !pins.clk_gate;
    if (pins.clk_gate)
    begin
      st_d.rd_pipe_q   = {st_q.rd_pipe_q[sdpci_pkg::READ_LAT-2:0], 1'b0};
      st_d.rd_data_q   = {st_q.rd_data_q[sdpci_pkg::READ_LAT-2:0], 16'h0000};
      st_d.mask_pipe_q = {st_q.mask_pipe_q[sdpci_pkg::MASK_DELAY-2:0], mask_now};
      st_d.dout_q      = st_q.rd_data_q[sdpci_pkg::READ_LAT-1];
      // read slot flag, lanes masked at the pins
      st_d.oe_q        = {sdpci_pkg::LANES{st_q.rd_pipe_q[sdpci_pkg::READ_LAT-1]}};
      case (op)
        sdpci_pkg::SDPCI_OP_ACT:
        begin
          st_d.open_q[bank] = 1'b1;
          st_d.row_q[bank]  = pins.addr;
        end
        sdpci_pkg::SDPCI_OP_READ:
        begin
          if (st_q.open_q[bank])
          begin
            st_d.rd_pipe_q[0] = 1'b1;
            st_d.rd_data_q[0] = rd_word;
            if (scope)
              st_d.open_q[bank] = 1'b0;
          end
        end
        sdpci_pkg::SDPCI_OP_WRITE:
        begin
          if (st_q.open_q[bank] && scope)
            st_d.open_q[bank] = 1'b0;
        end
        sdpci_pkg::SDPCI_OP_PRE:
        begin
          // scope chooses all or one, bank ignored for all
          if (scope)
            st_d.open_q = '0;
          else
            st_d.open_q[bank] = 1'b0;
        end
        sdpci_pkg::SDPCI_OP_MODE:
          st_d.mode_q = pins.addr;
        default:
          st_d.open_q = st_d.open_q;
      endcase
    end
    else
    begin
      // suspended edge: pipes and all outputs but gated frozen
      st_d.open_q = st_q.open_q;
    end
  end

  // ==========================================================
  // registers
  // rising-edge capture
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q        <= '0;
      st_q.mode_q <= sdpci_pkg::MODE_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // byte-lane arrays, kept out of the state struct
  // no reset so each lane can map to a memory; contents undefined until written
  for (genvar g = 0; g < sdpci_pkg::LANES; g++)
  begin : g_lane
    logic [LANE_W-1:0] lane_mem [DEPTH];

    always_ff @(posedge ref_clk)
    begin
      if (wr_hit && !mask_now[g])
        lane_mem[mem_idx] <= pins.data_lines_in[g*LANE_W +: LANE_W];
    end

    // array word read here, registered in the pipe
    assign rd_word[g*LANE_W +: LANE_W] = lane_mem[mem_idx];
  end : g_lane

  // ==========================================================
  // outputs
  assign pins.dev_data_out = st_q.dout_q;
  // mask sampled two edges before the host samples the data
  assign pins.dev_data_oe  = st_q.oe_q & ~st_q.mask_pipe_q[sdpci_pkg::MASK_DELAY-1];
  assign mode_word         = st_q.mode_q;
  assign bank_open         = st_q.open_q;
  assign gated             = st_q.gated_q;

endmodule : sdpci_device
`default_nettype wire

/* hw/sdpci_host.sv */
// sdpci_host: controller end, turns a one-cycle request into pin levels
// assumes: user holds req_valid one cycle per command; no command queue
`timescale 1ns/10ps
`default_nettype none
module sdpci_host (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  sdpci_if.host                              pins,
  input  wire logic                          req_valid,
  input  wire logic [2:0]                    req_cmd,
  input  wire logic [sdpci_pkg::BANK_W-1:0]  req_bank,
  input  wire logic [sdpci_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [sdpci_pkg::LANES-1:0]   req_mask,
  input  wire logic [sdpci_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic                          req_gate,
  output logic [sdpci_pkg::DATA_W-1:0]       rd_data,
  output logic                               rd_valid
);
  typedef struct packed {
    logic                          sel_n_q;
    logic [2:0]                    str_q;
    logic [sdpci_pkg::BANK_W-1:0]  bank_q;
    logic [sdpci_pkg::ADDR_W-1:0]  addr_q;
    logic [sdpci_pkg::LANES-1:0]   mask_q;
    logic [sdpci_pkg::DATA_W-1:0]  wdata_q;
    logic                          wr_oe_q;
    logic                          gate_q;
    logic [sdpci_pkg::READ_LAT+1:0] rd_pipe_q;
    logic [sdpci_pkg::DATA_W-1:0]  rdata_q;
    logic                          rvalid_q;
  } sdpci_host_s;

  sdpci_host_s st_q;
  sdpci_host_s st_d;

  always_comb
  begin
    st_d          = st_q;
    st_d.sel_n_q  = !req_valid;
    st_d.str_q    = req_valid ? req_cmd : sdpci_pkg::CMD_NOP;
    // address and bank presented with command
    st_d.bank_q   = req_bank;
    st_d.addr_q   = req_addr;
    st_d.mask_q   = req_mask;
    st_d.wdata_q  = req_wdata;
    st_d.wr_oe_q  = req_valid && req_cmd == sdpci_pkg::CMD_WRITE;
    st_d.gate_q   = req_gate;
    st_d.rd_pipe_q = {st_q.rd_pipe_q[sdpci_pkg::READ_LAT:0],
                      req_valid && req_cmd == sdpci_pkg::CMD_READ};
    // device data leaves its output register one edge after its pipe
    st_d.rvalid_q = st_q.rd_pipe_q[sdpci_pkg::READ_LAT+1];
    st_d.rdata_q  = pins.data_lines_in;
  end

  // levels launched from flops, stable at device edge
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q         <= '0;
      st_q.sel_n_q <= 1'b1;
      st_q.str_q   <= sdpci_pkg::CMD_NOP;
      st_q.gate_q  <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pins.clk_gate        = st_q.gate_q;
  assign pins.cmd_sel_n       = st_q.sel_n_q;
  assign pins.row_strobe_n    = st_q.str_q[2];
  assign pins.col_strobe_n    = st_q.str_q[1];
  assign pins.wr_strobe_n     = st_q.str_q[0];
  assign pins.bank_select_lsb = st_q.bank_q[0];
  assign pins.bank_select_msb = st_q.bank_q[1];
  assign pins.addr            = st_q.addr_q;
  assign pins.low_byte_mask   = st_q.mask_q[0];
  assign pins.high_byte_mask  = st_q.mask_q[1];
  assign pins.host_data_out   = st_q.wdata_q;
  assign pins.host_data_oe    = st_q.wr_oe_q;
  assign rd_data              = st_q.rdata_q;
  assign rd_valid             = st_q.rvalid_q;

endmodule : sdpci_host
`default_nettype wire

/* hw/sdpci_if.sv */
// sdpci_if: pin bundle between the memory device and its controller
// assumes: testbench resolves data_lines from the two enables
`timescale 1ns/10ps
`default_nettype none
interface sdpci_if;
  logic                             clk_gate;
  logic                             cmd_sel_n;
  logic                             row_strobe_n;
  logic                             col_strobe_n;
  logic                             wr_strobe_n;
  logic                             bank_select_lsb;
  logic                             bank_select_msb;
  logic [sdpci_pkg::ADDR_W-1:0]     addr;
  logic                             low_byte_mask;
  logic                             high_byte_mask;
  logic [sdpci_pkg::DATA_W-1:0]     host_data_out;
  logic                             host_data_oe;
  logic [sdpci_pkg::DATA_W-1:0]     dev_data_out;
  logic [sdpci_pkg::LANES-1:0]      dev_data_oe;
  logic [sdpci_pkg::DATA_W-1:0]     data_lines_in;

  modport device (
    input  clk_gate, cmd_sel_n, row_strobe_n, col_strobe_n, wr_strobe_n,
    input  bank_select_lsb, bank_select_msb, addr, low_byte_mask, high_byte_mask,
    input  data_lines_in,
    output dev_data_out, dev_data_oe
  );
  modport host (
    output clk_gate, cmd_sel_n, row_strobe_n, col_strobe_n, wr_strobe_n,
    output bank_select_lsb, bank_select_msb, addr, low_byte_mask, high_byte_mask,
    output host_data_out, host_data_oe,
    input  data_lines_in
  );
endinterface : sdpci_if
`default_nettype wire

/* hw/sdpci_pkg.sv */
// sdpci_pkg: shared constants and types for the sdram pin command interface
// assumes: both ends of the link run on the same ref_clk
`default_nettype none
package sdpci_pkg;

  // ==========================================================
  // widths, scope bit position and latencies
  localparam int ADDR_W      = 13;
  localparam int BANK_W      = 2;
  localparam int BANKS       = 4;
  localparam int DATA_W      = 16;
  localparam int LANES       = 2;
  localparam int COL_W_X16   = 9;
  localparam int COL_W_X8    = 10;
  localparam int SCOPE_BIT   = 10;
  localparam int MASK_DELAY  = 2;
  localparam int READ_LAT    = 2;

  // ==========================================================
  // commands as {row, col, write} strobe levels, active low
  localparam logic [2:0] CMD_NOP    = 3'h7;
  localparam logic [2:0] CMD_STOP   = 3'h6;
  localparam logic [2:0] CMD_READ   = 3'h5;
  localparam logic [2:0] CMD_WRITE  = 3'h4;
  localparam logic [2:0] CMD_ACT    = 3'h3;
  localparam logic [2:0] CMD_PRE    = 3'h2;
  localparam logic [2:0] CMD_REF    = 3'h1;
  localparam logic [2:0] CMD_MODE   = 3'h0;

  // ==========================================================
  // reset values
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;

  typedef enum logic [2:0] {
    SDPCI_OP_NOP,
    SDPCI_OP_ACT,
    SDPCI_OP_READ,
    SDPCI_OP_WRITE,
    SDPCI_OP_PRE,
    SDPCI_OP_MODE,
    SDPCI_OP_REF
  } sdpci_op_e;

endpackage : sdpci_pkg
`default_nettype wire

/* sim/sdpci_monitor.sv */
// sdpci_monitor: pin level checks on the link between host and device ends
// assumes: one ref_clk domain, reset synchronous active high
`timescale 1ns/10ps
`default_nettype none
module sdpci_monitor (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        clk_gate,
  input wire logic        cmd_sel_n,
  input wire logic        row_strobe_n,
  input wire logic        col_strobe_n,
  input wire logic        wr_strobe_n,
  input wire logic        bank_select_lsb,
  input wire logic        bank_select_msb,
  input wire logic [12:0] addr,
  input wire logic        low_byte_mask,
  input wire logic        high_byte_mask,
  input wire logic        host_data_oe,
  input wire logic [15:0] dev_data_out,
  input wire logic [1:0]  dev_data_oe
);
  logic [2:0] cmd;
  logic [1:0] bank;
  logic       take;
  logic [3:0] open_q;
  logic [3:0] open_d;
  assign cmd  = {row_strobe_n, col_strobe_n, wr_strobe_n};
  assign bank = {bank_select_msb, bank_select_lsb};
  assign take = clk_gate && !cmd_sel_n;
  // ==========================================================
  // open bank mirror, needed to know whether a read may answer
  always_comb
  begin
    open_d = open_q;
    if (take && cmd == sdpci_pkg::CMD_ACT)
      open_d[bank] = 1'b1;
    if (take && cmd == sdpci_pkg::CMD_PRE)
      open_d = addr[sdpci_pkg::SCOPE_BIT] ? 4'h0 : open_q & ~(4'h1 << bank);
    if (take && (cmd == sdpci_pkg::CMD_READ || cmd == sdpci_pkg::CMD_WRITE)
        && addr[sdpci_pkg::SCOPE_BIT])
      open_d[bank] = 1'b0;
  end
  always_ff @(posedge ref_clk)
    open_q <= reset ? 4'h0 : open_d;
  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence rd_run_s(hit);
    take && cmd == sdpci_pkg::CMD_READ && open_q[bank] == hit ##1 clk_gate [*2];
  endsequence
  lo_lane_mask_a:
    assert property (dev_data_oe[0] && $past(clk_gate) && $past(clk_gate, 2)
      |-> !$past(low_byte_mask, 2)) else $error("lower lane driven while masked");
  hi_lane_mask_a:
    assert property (dev_data_oe[1] && $past(clk_gate) && $past(clk_gate, 2)
      |-> !$past(high_byte_mask, 2)) else $error("upper lane driven while masked");
  oe_after_read_a:
    assert property ((|dev_data_oe) && $past(clk_gate) && $past(clk_gate, 2)
      && $past(clk_gate, 3) |-> $past(take && cmd == sdpci_pkg::CMD_READ, 3))
      else $error("drive without read");
  read_open_a:
    assert property (rd_run_s(1'b1) |=> dev_data_oe == ~{$past(high_byte_mask, 2),
      $past(low_byte_mask, 2)}) else $error("read to open bank not driven");
  read_closed_a:
    assert property (rd_run_s(1'b0) |=> dev_data_oe == 2'h0)
      else $error("read to closed bank driven");
  gate_freeze_a:
    assert property (!clk_gate |=> $stable(dev_data_oe) && $stable(dev_data_out))
      else $error("output moved on gated edge");
  host_oe_write_a:
    assert property (host_data_oe |-> !cmd_sel_n && cmd == sdpci_pkg::CMD_WRITE)
      else $error("host drives data without write");
  no_bus_clash_a:
    assert property (!(host_data_oe && (|dev_data_oe)))
      else $error("both ends drive data");
endmodule : sdpci_monitor
`default_nettype wire

/* sim/sdram_pin_command_interface_tb_top.sv */
// testbench: host and device joined, random command stream against a model
// assumes: design files compiled first; data bus resolved here from enables
`timescale 1ns/10ps
`default_nettype none
module sdram_pin_command_interface_tb_top;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        req_valid = 1'b0;
  logic [2:0]  req_cmd = 3'h7;
  logic [1:0]  req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [1:0]  req_mask = 2'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic        req_gate = 1'b1;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        gated;
  logic [12:0] mode_word;
  logic [3:0]  bank_open;
  logic [15:0] idle_pat = 16'h5a3c;
  logic [3:0]  m_open = 4'h0;
  logic [3:0]  rd_hist = 4'h0;
  logic [12:0] m_mode = 13'h0000;
  logic [15:0] mem [128];
  logic [12:0] m_row [4] = '{default: 13'h0000};
  logic        desel = 1'b0;
  logic [31:0] rdq [$];
  logic [31:0] pend = 32'h0;
  logic [31:0] e;
  logic        rd_pend = 1'b0;
  int          fail_count = 0;
  int          tests_run = 0;
  int          seed = 32'h88be;
  int          i;
  sdpci_if bus ();
  always #12.5 ref_clk = ~ref_clk;
  // ==========================================================
  // bus resolution; undriven lanes toggle so stale data never matches
  always @(posedge ref_clk)
    idle_pat <= ~idle_pat;
  assign bus.data_lines_in[7:0] = bus.dev_data_oe[0] ? bus.dev_data_out[7:0]
    : bus.host_data_oe ? bus.host_data_out[7:0] : idle_pat[7:0];
  assign bus.data_lines_in[15:8] = bus.dev_data_oe[1] ? bus.dev_data_out[15:8]
    : bus.host_data_oe ? bus.host_data_out[15:8] : idle_pat[15:8];
  sdpci_host sdpci_host_inst (.ref_clk(ref_clk), .reset(reset), .pins(bus.host),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_mask(req_mask), .req_wdata(req_wdata), .req_gate(req_gate), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sdpci_device sdpci_device_inst (.ref_clk(ref_clk), .reset(reset), .pins(bus.device),
    .mode_word(mode_word), .bank_open(bank_open), .gated(gated));
  sdpci_monitor sdpci_monitor_inst (.ref_clk(ref_clk), .reset(reset),
    .clk_gate(bus.clk_gate), .cmd_sel_n(bus.cmd_sel_n), .row_strobe_n(bus.row_strobe_n),
    .col_strobe_n(bus.col_strobe_n), .wr_strobe_n(bus.wr_strobe_n),
    .bank_select_lsb(bus.bank_select_lsb), .bank_select_msb(bus.bank_select_msb),
    .addr(bus.addr), .low_byte_mask(bus.low_byte_mask), .high_byte_mask(bus.high_byte_mask),
    .host_data_oe(bus.host_data_oe), .dev_data_out(bus.dev_data_out),
    .dev_data_oe(bus.dev_data_oe));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // one command per cycle; the model follows what the device must do
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [1:0] m, input logic [15:0] d);
    logic [15:0] lm;
    logic [6:0]  k;
    lm = {{8{~m[1]}}, {8{~m[0]}}};
    // storage is bank, low bit of the open row, low column bits
    k = {b, m_row[b][0], a[3:0]};
    // no write in the slot where the device answers an earlier read
    if (c == sdpci_pkg::CMD_WRITE && rd_hist[2])
      c = sdpci_pkg::CMD_NOP;
    @(negedge ref_clk);
    {req_valid, req_cmd, req_bank, req_addr, req_mask, req_wdata} = {!desel, c, b, a, m, d};
    // a deselected slot changes nothing in the model
    if (desel)
      c = sdpci_pkg::CMD_NOP;
    if (rd_pend)
      rdq.push_back({pend[31:16] & lm, pend[15:0]});
    {rd_pend, rd_hist} = {1'b0, rd_hist[2:0], 1'b0};
    // row held open for later accesses
    if (req_gate && c == sdpci_pkg::CMD_ACT)
      {m_open[b], m_row[b]} = {1'b1, a};
    if (req_gate && c == sdpci_pkg::CMD_PRE)
      m_open = a[10] ? 4'h0 : m_open & ~(4'h1 << b);
    if (req_gate && c == sdpci_pkg::CMD_MODE)
      m_mode = a;
    if (req_gate && c == sdpci_pkg::CMD_WRITE && m_open[b])
      mem[k] = (mem[k] & ~lm) | (d & lm);
    if (req_gate && c == sdpci_pkg::CMD_READ)
      {rd_pend, rd_hist[0], pend} = {2'b11, m_open[b] ? 16'hffff : 16'h0000, mem[k]};
    if (req_gate && (c == sdpci_pkg::CMD_READ || c == sdpci_pkg::CMD_WRITE) && a[10])
      m_open[b] = 1'b0;
  endtask : issue
  task automatic settle();
    repeat (6) issue(sdpci_pkg::CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0000);
    check({12'h000, bank_open}, {12'h000, m_open});
    check({3'h0, mode_word}, {3'h0, m_mode});
  endtask : settle
  always @(negedge ref_clk)
    if (!reset && rd_valid === 1'b1)
    begin
      e = rdq.size() != 0 ? rdq.pop_front() : {16'hffff, ~rd_data};
      check(rd_data & e[31:16], e[15:0] & e[31:16]);
    end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    // fill both stand-in rows of every bank before any random read
    for (i = 0; i < 128; i++)
    begin
      if (i % 16 == 0)
        issue(sdpci_pkg::CMD_ACT, i[5:4], {12'($random(seed)), i[6]}, 2'h0, 16'h0000);
      issue(sdpci_pkg::CMD_WRITE, i[5:4], {9'h000, i[3:0]}, 2'h0, 16'($random(seed)));
    end
    for (i = 0; i < 400; i++)
    begin
      // about one slot in eight is a deselect
      desel = ($random(seed) & 7) == 0;
      issue(3'($random(seed)), 2'($random(seed)), 13'($random(seed)), 2'($random(seed)),
            16'($random(seed)));
      desel = 1'b0;
      if (i % 25 == 24)
        settle();
    end
    req_gate = 1'b0;
    issue(sdpci_pkg::CMD_ACT, 2'h3, 13'h0400, 2'h0, 16'h0000);
    issue(sdpci_pkg::CMD_PRE, 2'h0, 13'h0400, 2'h0, 16'h0000);
    settle();
    check({15'h0000, gated}, 16'h0001);
    req_gate = 1'b1;
    settle();
    check({15'h0000, gated}, 16'h0000);
    check(16'(rdq.size()), 16'h0000);
    end_of_test();
  end
  // whole run is under a thousand cycles; twenty thousand means a hang
  initial
  begin
    #(25 * 20000);
    fail_count++;
    end_of_test();
  end
endmodule : sdram_pin_command_interface_tb_top
`default_nettype wire
